// [rtl/bcc_cmd_ctrl.sv]
// bus command controller: status decode, command strobes, transceiver control
//
// Overview of operation
// - passive status keeps every command output high and inactive.
// - all commands and controls are timed from the single clock.
// - address strobe is active high; address is caught on its falling edge.
// - data transceiver enable is active high during a transfer.
// - direction is high for writes, low for reads.
// - commands are driven 110 to 250 ns after the grant goes low.
// - grant going inactive releases the command drivers at the next clock edge.
// - in io-bus mode the grant does not affect io commands.
// - command qualify low forces commands and transceiver enables inactive.
// - strap high selects io-bus mode, low system-bus mode; held static.
// - early io write strobe has read-command timing, active low.
// - early memory write strobe has read-command timing, active low.
// - memory write and io write strobes go low to store data.
// - memory read and io read strobes go low to fetch data.
// - interrupt acknowledge strobe goes low during acknowledge cycles.
// - system-bus mode: dual output is active-high cascade strobe in acknowledge.
// - status code decodes to the eight documented machine cycle kinds.
// - io-bus mode: io commands go at once, peripheral enable steers transceiver.
// - with command qualify low, commands stay driven high, not released.
module bcc_cmd_ctrl
   import bcc_pkg::*;
#(
   parameter int unsigned MIN_CYC = GRANT_MIN_CYC,
   parameter int unsigned MAX_CYC = GRANT_MAX_CYC
)
(
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic [2:0] cpu_status_code_i,
   input  wire logic       arbitration_grant_n_i,
   input  wire logic       command_qualify_i,
   input  wire logic       io_bus_select_i,
   output logic            irq_ack_n_o,
   output logic            io_read_n_o,
   output logic            io_write_n_o,
   output logic            early_io_write_n_o,
   output logic            mem_read_n_o,
   output logic            mem_write_n_o,
   output logic            early_mem_write_n_o,
   output logic            io_cmd_oe_o,
   output logic            mem_cmd_oe_o,
   output logic            address_strobe_o,
   output logic            data_xcvr_enable_o,
   output logic            xcvr_direction_o,
   output logic            cascade_or_peripheral_enable_o
);

   if (MIN_CYC + 1 > MAX_CYC)
   begin : g_bad_param
      $error("grant window parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   bcc_cmd_type      dec_cmd;
   logic             dec_passive;
   logic             dec_write;
   logic             grant_ready;
   bcc_seq_type      seq_ff;
   bcc_seq_type      nxt_seq;
   bcc_cmd_type      cyc_cmd_ff;
   bcc_cmd_type      nxt_cyc_cmd;
   logic             cyc_write_ff;
   logic             nxt_cyc_write;
   logic             strap_ff;
   logic             strap_taken_ff;
   bcc_cmd_type      nxt_act;
   logic [CMD_W-1:0] cmd_n_ff;
   logic [CMD_W-1:0] nxt_cmd_n;
   logic             io_oe_ff;
   logic             mem_oe_ff;
   logic             ale_ff;
   logic             den_ff;
   logic             dtr_ff;
   logic             dual_ff;
   logic             nxt_io_cyc;
   logic             nxt_xfer;

   ////////////////////////////////////////////////////////////////////////////
   // status decode and grant delay

   bcc_status_decode u_decode
   (
      .status_i  (cpu_status_code_i),
      .cmd_o     (dec_cmd),
      .passive_o (dec_passive),
      .write_o   (dec_write)
   );

   bcc_grant_delay #(
      .MIN_CYC (MIN_CYC),
      .MAX_CYC (MAX_CYC),
      .CNT_W   (GRANT_CNT_W)
   ) u_grant
   (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .grant_n_i (arbitration_grant_n_i),
      .ready_o   (grant_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode strap, caught once after reset release

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         strap_ff       <= 1'b0;
         strap_taken_ff <= 1'b0;
      end
      else if (!strap_taken_ff)
      begin
         strap_ff       <= io_bus_select_i;
         strap_taken_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // machine cycle sequencer

   always_comb
   begin
      nxt_seq       = seq_ff;
      nxt_cyc_cmd   = cyc_cmd_ff;
      nxt_cyc_write = cyc_write_ff;
      case (seq_ff)
         SEQ_IDLE :
         begin
            if (!dec_passive)
            begin
               nxt_seq       = SEQ_ADDR;
               nxt_cyc_cmd   = dec_cmd;
               nxt_cyc_write = dec_write;
            end
         end
         SEQ_ADDR : nxt_seq = dec_passive ? SEQ_IDLE : SEQ_DATA;
         SEQ_DATA : nxt_seq = dec_passive ? SEQ_IDLE : SEQ_HOLD;
         SEQ_HOLD : nxt_seq = dec_passive ? SEQ_IDLE : SEQ_HOLD;
         default  : nxt_seq = SEQ_IDLE;
      endcase
      if (nxt_seq == SEQ_IDLE)
      begin
         nxt_cyc_cmd   = CMD_NONE;
         nxt_cyc_write = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         seq_ff       <= SEQ_IDLE;
         cyc_cmd_ff   <= CMD_NONE;
         cyc_write_ff <= 1'b0;
      end
      else
      begin
         seq_ff       <= nxt_seq;
         cyc_cmd_ff   <= nxt_cyc_cmd;
         cyc_write_ff <= nxt_cyc_write;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command phase decode

   always_comb
   begin
      nxt_act   = CMD_NONE;
      nxt_xfer  = (nxt_seq == SEQ_DATA) || (nxt_seq == SEQ_HOLD);
      nxt_io_cyc = nxt_cyc_cmd.irq_ack || nxt_cyc_cmd.io_read || nxt_cyc_cmd.io_write;
      if (nxt_xfer && command_qualify_i)
      begin
         nxt_act.irq_ack         = nxt_cyc_cmd.irq_ack;
         nxt_act.io_read         = nxt_cyc_cmd.io_read;
         nxt_act.mem_read        = nxt_cyc_cmd.mem_read;
         nxt_act.early_io_write  = nxt_cyc_cmd.early_io_write;
         nxt_act.early_mem_write = nxt_cyc_cmd.early_mem_write;
         if (nxt_seq == SEQ_HOLD)
         begin
            nxt_act.io_write  = nxt_cyc_cmd.io_write;
            nxt_act.mem_write = nxt_cyc_cmd.mem_write;
         end
      end
      nxt_cmd_n = ~nxt_act;
   end

   // strobes are driven high when inactive, never left floating
   for (genvar i = 0; i < CMD_W; i++)
   begin : g_cmd
      always_ff @(posedge clock_i or negedge rstn_i)
      begin
         if (!rstn_i)
            cmd_n_ff[i] <= 1'b1;
         else
            cmd_n_ff[i] <= nxt_cmd_n[i];
      end
   end

   assign {irq_ack_n_o, io_read_n_o, io_write_n_o, early_io_write_n_o,
           mem_read_n_o, mem_write_n_o, early_mem_write_n_o} = cmd_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // driver enables from arbitration

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mem_oe_ff <= 1'b0;
         io_oe_ff  <= 1'b0;
      end
      else
      begin
         mem_oe_ff <= grant_ready;
         io_oe_ff  <= strap_taken_ff && strap_ff ? 1'b1 : grant_ready;
      end
   end

   assign mem_cmd_oe_o = mem_oe_ff;
   assign io_cmd_oe_o  = io_oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // address strobe and transceiver controls

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ale_ff  <= 1'b0;
         den_ff  <= 1'b0;
         dtr_ff  <= 1'b1;
         dual_ff <= 1'b0;
      end
      else
      begin
         // one-cycle pulse, its fall latches the address
         ale_ff <= (nxt_seq == SEQ_ADDR);
         // system transceiver, not used for io cycles in io-bus mode
         den_ff <= nxt_xfer && command_qualify_i &&
                   !(strap_ff && nxt_io_cyc) &&
                   (nxt_cyc_cmd != CMD_NONE);
         // receive while any cycle other than a write runs, halt included
         dtr_ff <= (nxt_seq == SEQ_IDLE) || nxt_cyc_write;
         if (strap_ff)
            dual_ff <= !(nxt_xfer && command_qualify_i && nxt_io_cyc);
         else
            dual_ff <= (nxt_seq == SEQ_ADDR) && nxt_cyc_cmd.irq_ack;
      end
   end

   assign address_strobe_o               = ale_ff;
   assign data_xcvr_enable_o             = den_ff;
   assign xcvr_direction_o               = dtr_ff;
   assign cascade_or_peripheral_enable_o = dual_ff;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   // edge after the grant falls, one before the last, at which the drivers are still off
   localparam int EARLY_GAP = int'(MIN_CYC) - 1;

   a_passive_quiet: assert property (
      (cpu_status_code_i == ST_PASSIVE) |=> (cmd_n_ff == {CMD_W{1'b1}}))
      else $error("command active during passive status");

   a_ale_start: assert property (
      (seq_ff == SEQ_IDLE && cpu_status_code_i != ST_PASSIVE) |=> address_strobe_o)
      else $error("address strobe missing at cycle start");

   a_ale_single: assert property (
      address_strobe_o |=> !address_strobe_o)
      else $error("address strobe longer than one cycle");

   a_dir_write: assert property (
      $fell(mem_write_n_o) || $fell(io_write_n_o) |-> xcvr_direction_o)
      else $error("direction low during write");

   a_dir_read: assert property (
      $fell(mem_read_n_o) || $fell(io_read_n_o) |-> !xcvr_direction_o)
      else $error("direction high during read");

   a_grant_early: assert property (
      $fell(arbitration_grant_n_i) |-> !mem_cmd_oe_o ##EARLY_GAP !mem_cmd_oe_o)
      else $error("command drivers enabled too early");

   a_grant_late: assert property (
      ($fell(arbitration_grant_n_i) ##1 !arbitration_grant_n_i [*8]
       ##1 !arbitration_grant_n_i ##1 !arbitration_grant_n_i) |=> mem_cmd_oe_o)
      else $error("command drivers enabled too late");

   a_grant_release: assert property (
      arbitration_grant_n_i |=> !mem_cmd_oe_o)
      else $error("command drivers not released");

   a_io_free: assert property (
      (strap_ff && $past(strap_ff)) |-> io_cmd_oe_o)
      else $error("io commands depend on grant in io-bus mode");

   a_qualify_off: assert property (
      !command_qualify_i |=> (cmd_n_ff == {CMD_W{1'b1}}) && !data_xcvr_enable_o)
      else $error("commands active while qualify low");

   a_write_order: assert property (
      $fell(mem_write_n_o) |-> !$past(early_mem_write_n_o))
      else $error("normal write before early write");

   c_mem_read: cover property ($fell(mem_read_n_o) && mem_cmd_oe_o);
   c_io_write: cover property ($fell(io_write_n_o));
   c_irq_ack:  cover property ($fell(irq_ack_n_o) ##1 !irq_ack_n_o);

endmodule : bcc_cmd_ctrl

// [rtl/bcc_pkg.sv]
// shared types and constants of the bus command controller
package bcc_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned GRANT_MIN_NS  = 110;
   localparam int unsigned GRANT_MAX_NS  = 250;
   localparam int unsigned GRANT_MIN_CYC = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GRANT_MAX_CYC = GRANT_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned GRANT_CNT_W   = 5;

   localparam logic [2:0] ST_IRQ_ACK  = 3'h0;
   localparam logic [2:0] ST_IO_READ  = 3'h1;
   localparam logic [2:0] ST_IO_WRITE = 3'h2;
   localparam logic [2:0] ST_HALT     = 3'h3;
   localparam logic [2:0] ST_CODE     = 3'h4;
   localparam logic [2:0] ST_MEM_READ = 3'h5;
   localparam logic [2:0] ST_MEM_WR   = 3'h6;
   localparam logic [2:0] ST_PASSIVE  = 3'h7;

   localparam int unsigned CMD_W = 7;

   // active-high command set of one machine cycle
   typedef struct packed {
      logic irq_ack;
      logic io_read;
      logic io_write;
      logic early_io_write;
      logic mem_read;
      logic mem_write;
      logic early_mem_write;
   } bcc_cmd_type;

   localparam bcc_cmd_type CMD_NONE = '{default: 1'b0};

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ADDR = 2'b01,
      SEQ_DATA = 2'b10,
      SEQ_HOLD = 2'b11
   } bcc_seq_type;

   function automatic bcc_cmd_type bcc_decode(input logic [2:0] code);
      bcc_cmd_type c;
      c = CMD_NONE;
      case (code)
         ST_IRQ_ACK  : c.irq_ack = 1'b1;
         ST_IO_READ  : c.io_read = 1'b1;
         ST_IO_WRITE :
         begin
            c.io_write       = 1'b1;
            c.early_io_write = 1'b1;
         end
         ST_CODE, ST_MEM_READ : c.mem_read = 1'b1;
         ST_MEM_WR   :
         begin
            c.mem_write       = 1'b1;
            c.early_mem_write = 1'b1;
         end
         default : c = CMD_NONE;
      endcase
      return c;
   endfunction : bcc_decode

endpackage : bcc_pkg

// [rtl/bcc_status_decode.sv]
// status code decoder of the bus command controller
module bcc_status_decode
   import bcc_pkg::*;
(
   input  wire logic [2:0]  status_i,
   output bcc_cmd_type      cmd_o,
   output logic             passive_o,
   output logic             write_o
);

   always_comb
   begin
      cmd_o     = bcc_decode(status_i);
      passive_o = (status_i == ST_PASSIVE);
      write_o   = (status_i == ST_IO_WRITE) || (status_i == ST_MEM_WR);
   end

endmodule : bcc_status_decode

// [rtl/bcc_grant_delay.sv]
// delays the arbitration grant before commands may be driven
module bcc_grant_delay
   import bcc_pkg::*;
#(
   parameter int unsigned MIN_CYC = GRANT_MIN_CYC,
   parameter int unsigned MAX_CYC = GRANT_MAX_CYC,
   parameter int unsigned CNT_W   = GRANT_CNT_W
)
(
   input  wire logic clock_i,
   input  wire logic rstn_i,
   input  wire logic grant_n_i,
   output logic      ready_o
);

   if (MIN_CYC < 1 || MIN_CYC + 1 > MAX_CYC || MIN_CYC >= (1 << CNT_W))
   begin : g_bad_param
      $error("grant delay parameters out of range");
   end

   localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(MIN_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt_ff;

   // counts low cycles of the grant, saturates
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_ff <= '0;
      else if (grant_n_i)
         cnt_ff <= '0;
      else if (cnt_ff != CNT_TOP)
         cnt_ff <= cnt_ff + CNT_ONE;
   end

   // withdrawn at once when the grant goes away
   assign ready_o = !grant_n_i && (cnt_ff == CNT_TOP);

endmodule : bcc_grant_delay

// [tb/bcc_cpu_model.sv]
// processor status model: drives one machine cycle per request
module bcc_cpu_model
   import bcc_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic       req_i,
   input  wire logic [2:0] code_i,
   output logic [2:0]      cpu_status_code_o,
   output logic            busy_o
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] left_ff;

   // code held five edges, then passive at least four edges
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cpu_status_code_o <= ST_PASSIVE;
         left_ff           <= 4'h0;
         busy_o            <= 1'b0;
      end
      else if (req_i && !busy_o)
      begin
         cpu_status_code_o <= code_i;
         left_ff           <= 4'h7;
         busy_o            <= 1'b1;
      end
      else if (left_ff != 4'h0)
      begin
         left_ff <= left_ff - 4'h1;
         if (left_ff == 4'h3)
            cpu_status_code_o <= ST_PASSIVE;
      end
      else
         busy_o <= 1'b0;
   end

endmodule : bcc_cpu_model

// [tb/bcc_cmd_ctrl_tb_top.sv]
// testbench of the bus command controller
module bcc_cmd_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bcc_pkg::*;

   localparam int unsigned T_MIN = 2;
   localparam int unsigned T_MAX = 3;

   typedef struct packed {
      logic [6:0] cmd;
      logic       data_xcvr_enable;
      logic       dir;
      logic       chk;
      logic       dual;
      logic       casc;
      logic       chkc;
   } bcc_tb_exp_type;

   ////////////////////////////////////////////////////////////////////////////////
   logic           clock_i;
   logic           rstn_i;
   logic [2:0]     status;
   logic           grant_n;
   logic           qual;
   logic           io_sel;
   logic           req;
   logic [2:0]     code;
   logic           busy;
   logic [6:0]     cmd_n;
   logic           io_oe;
   logic           mem_oe;
   logic           strobe;
   logic           data_xcvr_enable;
   logic           dir;
   logic           dual;
   int             errors;
   int             checked;
   bcc_tb_exp_type exp_q[$];

   bcc_cmd_ctrl #(.MIN_CYC(T_MIN), .MAX_CYC(T_MAX)) bcc_cmd_ctrl_inst (
      .clock_i                        (clock_i),
      .rstn_i                         (rstn_i),
      .cpu_status_code_i              (status),
      .arbitration_grant_n_i          (grant_n),
      .command_qualify_i              (qual),
      .io_bus_select_i                (io_sel),
      .irq_ack_n_o                    (cmd_n[6]),
      .io_read_n_o                    (cmd_n[5]),
      .io_write_n_o                   (cmd_n[4]),
      .early_io_write_n_o             (cmd_n[3]),
      .mem_read_n_o                   (cmd_n[2]),
      .mem_write_n_o                  (cmd_n[1]),
      .early_mem_write_n_o            (cmd_n[0]),
      .io_cmd_oe_o                    (io_oe),
      .mem_cmd_oe_o                   (mem_oe),
      .address_strobe_o               (strobe),
      .data_xcvr_enable_o             (data_xcvr_enable),
      .xcvr_direction_o               (dir),
      .cascade_or_peripheral_enable_o (dual)
   );

   bcc_cpu_model bcc_cpu_model_inst (
      .clock_i           (clock_i),
      .rstn_i            (rstn_i),
      .req_i             (req),
      .code_i            (code),
      .cpu_status_code_o (status),
      .busy_o            (busy)
   );

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic fail(input string msg);
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail

   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      checked++;
      if (got !== exp)
         fail(msg);
   endtask : cmp_bit

   task automatic cmp_cmd(input logic [6:0] got, input logic [6:0] exp);
      checked++;
      if (got !== exp)
         fail($sformatf("strobes %h expected %h", got, exp));
   endtask : cmp_cmd

   function automatic bcc_tb_exp_type exp_of(input logic [2:0] c, input logic q, input logic io);
      bcc_tb_exp_type e;
      logic           io_cyc;
      logic           mem_cyc;
      e = '{cmd: 7'h7f, data_xcvr_enable: 1'b0, dir: 1'b0, chk: 1'b1, dual: io, casc: 1'b0, chkc: q & ~io};
      io_cyc  = (c <= 3'h2);
      mem_cyc = (c >= 3'h4) && (c <= 3'h6);
      e.casc  = (c == 3'h0);
      case (c)
         3'h0 : e.cmd[6] = 1'b0;
         3'h1 : e.cmd[5] = 1'b0;
         3'h2 : {e.cmd[4], e.cmd[3], e.dir} = 3'b001;
         3'h3 : e.chk = 1'b0;
         3'h4, 3'h5 : e.cmd[2] = 1'b0;
         3'h6 : {e.cmd[1], e.cmd[0], e.dir} = 3'b001;
         default : e.chk = 1'b1;
      endcase
      if (!q)
         e.cmd = 7'h7f;
      else if (io && io_cyc)
         e.dual = 1'b0;
      else if (io_cyc || mem_cyc)
         e.data_xcvr_enable = 1'b1;
      return e;
   endfunction : exp_of

   task automatic do_cycle(input logic [2:0] c, input logic q);
      int n;
      n = 0;
      @(posedge clock_i);
      qual <= q;
      @(posedge clock_i);
      if (c != ST_PASSIVE)
         exp_q.push_back(exp_of(c, q, io_sel));
      code <= c;
      req  <= 1'b1;
      @(posedge clock_i);
      req <= 1'b0;
      @(posedge clock_i);
      while (busy === 1'b1 && n < 30)
      begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 30)
      begin
         fail("status model hung");
         stop_test();
      end
      cmp_cmd(cmd_n, 7'h7f);
      cmp_bit(data_xcvr_enable, 1'b0, "enable left on when passive");
      cmp_bit(io_oe, 1'b1, "io drivers released");
      cmp_bit(mem_oe, ~grant_n, "mem drivers vs grant");
   endtask : do_cycle

   task automatic grant_check();
      int   n;
      logic seen;
      n    = 0;
      seen = 1'b0;
      @(posedge clock_i);
      grant_n <= 1'b0;
      @(posedge clock_i);
      while (mem_oe !== 1'b1 && n < 40)
      begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 40)
      begin
         fail("grant never enabled drivers");
         stop_test();
      end
      cmp_bit(logic'(n - 1 >= T_MIN && n - 1 <= T_MAX), 1'b1, "grant delay");
      cmp_bit(io_oe, 1'b1, "io drivers after grant");
      grant_n <= 1'b1;
      repeat (2) @(posedge clock_i);
      cmp_bit(mem_oe, 1'b0, "drivers kept after grant loss");
      grant_n <= 1'b0;
      repeat (T_MIN - 1) @(posedge clock_i);
      grant_n <= 1'b1;
      repeat (8)
      begin
         @(posedge clock_i);
         seen = seen | (mem_oe !== 1'b0);
      end
      cmp_bit(seen, 1'b0, "short grant enabled drivers");
      grant_n <= 1'b0;
      repeat (T_MAX + 3) @(posedge clock_i);
   endtask : grant_check

   ////////////////////////////////////////////////////////////////////////////////
   // monitor: one note per address strobe
   initial
   begin
      bcc_tb_exp_type e;
      forever
      begin
         @(posedge clock_i);
         if (rstn_i === 1'b1 && strobe === 1'b1)
         begin
            if (exp_q.size() == 0)
               fail("unexpected address strobe");
            else
            begin
               e = exp_q.pop_front();
               if (e.chkc)
                  cmp_bit(dual, e.casc, "cascade strobe");
               @(posedge clock_i);
               cmp_cmd(cmd_n, e.cmd | 7'h12);
               cmp_bit(strobe, 1'b0, "strobe not one cycle");
               @(posedge clock_i);
               cmp_cmd(cmd_n, e.cmd);
               cmp_bit(data_xcvr_enable, e.data_xcvr_enable, "data enable");
               if (e.chk)
                  cmp_bit(dir, e.dir, "direction");
               cmp_bit(dual, e.dual, "dual output");
            end
         end
      end
   end

   initial
   begin
      int m;
      int c;
      rstn_i  = 1'b0;
      grant_n = 1'b1;
      qual    = 1'b1;
      io_sel  = 1'b0;
      req     = 1'b0;
      code    = ST_PASSIVE;
      errors  = 0;
      checked = 0;
      void'($urandom(7));
      for (m = 0; m < 2; m++)
      begin
         rstn_i  <= 1'b0;
         grant_n <= 1'b1;
         io_sel  <= m[0];
         repeat (10) @(posedge clock_i);
         rstn_i <= 1'b1;
         repeat (3) @(posedge clock_i);
         if (m == 0)
            grant_check();
         for (c = 0; c < 8; c++)
            do_cycle(c[2:0], 1'b1);
         do_cycle(ST_IO_READ, 1'b0);
         for (c = 0; c < 12; c++)
            do_cycle(3'($urandom_range(6, 0)), 1'($urandom_range(1, 0)));
      end
      repeat (4) @(posedge clock_i);
      if (exp_q.size() != 0)
         fail("address strobe missing");
      stop_test();
   end

endmodule : bcc_cmd_ctrl_tb_top
